// ### anpr_consts.svh
/*
 * Constants for the auto-negotiation page registers: register offsets, field positions,
 * reset values and the port count.
 * Assumes it is included by its bare name. It holds definitions only.
 */
// Operation
// - partner ability register is read-only, shows last received partner code word
// - it holds base page or next page, whichever arrived last
// - each of four ports has its own copy of all three registers
// - bit 15 is partner next page, bit 14 partner acknowledge
// - base page: bit 13 remote fault, bits 12:5 technology ability
// - base page: bits 4:0 selector field as received
// - next page: bit 13 message page one, unformatted zero
// - next page: bit 12 can comply, bit 11 partner toggle
// - next page: bits 10:0 message code; partner fields reset to zero
// - expansion bits 15:4 read zero, writes ignored
// - expansion bit 3 partner next page able, resets zero
// - expansion bit 2 constant one, local port next page able
// - expansion bit 1 sets on new page, cleared by management read
// - expansion bit 0 partner auto-negotiation able, resets zero
// - next-page transmit register supplies outgoing next page code word
// - next-page transmit register resets to 0x2001
// - transmit bits 15 and 13 writable, reset 0 and 1
// - transmit bit 12 writable reset 0, bit 14 reads zero
// - transmit bit 11 read-only, shows device-generated toggle
`ifndef ANPR_CONSTS_SVH
`define ANPR_CONSTS_SVH

`define ANPR_NPORTS        4
`define ANPR_OFS_PARTNER   5'h05
`define ANPR_OFS_EXPANSION 5'h06
`define ANPR_OFS_NEXTPAGE  5'h07

`define ANPR_BIT_NP        15
`define ANPR_BIT_ACK       14
`define ANPR_BIT_MP        13
`define ANPR_BIT_ACK2      12
`define ANPR_BIT_TOGGLE    11
`define ANPR_MSG_HI        10

`define ANPR_EXP_LP_NP     3
`define ANPR_EXP_NP_ABLE   2
`define ANPR_EXP_PAGE_RX   1
`define ANPR_EXP_LP_AN     0

`define ANPR_PARTNER_RST   16'h0000
`define ANPR_NEXTPAGE_RST  16'h2001
`define ANPR_NP_WMASK      16'hb7ff

`endif

// ### anpr_pkg.sv
/*
 * Types shared by the page register bank.
 * Assumes anpr_consts.svh gives the port count.
 */
`include "anpr_consts.svh"

package anpr_pkg;
  typedef logic [15:0] anpr_word_t;
  typedef logic [1:0]  anpr_port_t;
  typedef logic [4:0]  anpr_regad_t;
endpackage

// ### anpr_port_if.sv
/*
 * Per-port bundle between the bank top and one port's register slice.
 * Assumes one instance per port, all on CORE_CLK.
 */
`timescale 1ns/100ps

interface anpr_port_if;
  logic                 wr_np;
  logic                 rd_exp;
  anpr_pkg::anpr_word_t wdata;
  logic                 rx_page;
  anpr_pkg::anpr_word_t rx_word;
  logic                 lp_an_able;
  logic                 tx_base;
  logic                 base_toggle;
  logic                 tx_next;
  anpr_pkg::anpr_word_t partner;
  anpr_pkg::anpr_word_t expansion;
  anpr_pkg::anpr_word_t nextpage;

  modport top (output wr_np, rd_exp, wdata, rx_page, rx_word, lp_an_able, tx_base, base_toggle, tx_next,
               input partner, expansion, nextpage);
  modport port (input wr_np, rd_exp, wdata, rx_page, rx_word, lp_an_able, tx_base, base_toggle, tx_next,
                output partner, expansion, nextpage);
endinterface

// ### anpr_port.sv
/*
 * One port's partner ability, expansion and next-page transmit registers.
 * Assumes strobes are one-cycle pulses on CORE_CLK from the bank top.
 */
`timescale 1ns/100ps
`include "anpr_consts.svh"

module anpr_port (
  // clock and reset
  input wire logic   clk,
  input wire logic   rst,
  // bundle
  anpr_port_if.port  p
);
  anpr_pkg::anpr_word_t partner_q;
  logic                 lp_np_q;
  logic                 page_rx_q;
  logic                 lp_an_q;
  anpr_pkg::anpr_word_t np_q;
  logic                 toggle_q;

  // last received word, base or next page, kept whole so every field shows as sent
  always_ff @(posedge clk) begin
    if (rst) begin
      partner_q <= `ANPR_PARTNER_RST;
    end else if (p.rx_page) begin
      partner_q <= p.rx_word;
    end
  end

  // arrival wins over a clearing read in the same cycle so no page is missed
  always_ff @(posedge clk) begin
    if (rst) begin
      page_rx_q <= 1'b0;
    end else if (p.rx_page) begin
      page_rx_q <= 1'b1;
    end else if (p.rd_exp) begin
      page_rx_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      lp_np_q <= 1'b0;
      lp_an_q <= 1'b0;
    end else begin
      lp_an_q <= p.lp_an_able;
      if (p.rx_page && p.rx_word[`ANPR_BIT_NP]) begin
        lp_np_q <= 1'b1;
      end else if (p.tx_base) begin
        lp_np_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      np_q <= `ANPR_NEXTPAGE_RST;
    end else if (p.wr_np) begin
      np_q <= p.wdata & `ANPR_NP_WMASK;
    end
  end

  // toggle for the outgoing page
  always_ff @(posedge clk) begin
    if (rst) begin
      toggle_q <= 1'b0;
    end else if (p.tx_base) begin
      toggle_q <= ~p.base_toggle;
    end else if (p.tx_next) begin
      toggle_q <= ~toggle_q;
    end
  end

  assign p.partner   = partner_q;
  assign p.expansion = {12'h000, lp_np_q, 1'b1, page_rx_q, lp_an_q};
  assign p.nextpage  = {np_q[15:12], toggle_q, np_q[`ANPR_MSG_HI:0]};
endmodule

// ### anpr_bank.sv
/*
 * Four-port auto-negotiation page register bank reached through the management
 * register port (port and register address, read and write strobes).
 * Assumes the management frame decoder issues one-cycle strobes and samples
 * read data one cycle after the read strobe; the arbitration logic gives page
 * events per port as one-cycle pulses. All inputs are synchronous to CORE_CLK.
 */
`timescale 1ns/100ps
`include "anpr_consts.svh"

module anpr_bank (
  // clock and reset
  input  wire logic                  CORE_CLK,
  input  wire logic                  RST,
  // management register port
  input  wire logic                  MGMT_RD,
  input  wire logic                  MGMT_WR,
  input  wire anpr_pkg::anpr_port_t  MGMT_PORT,
  input  wire anpr_pkg::anpr_regad_t MGMT_REG,
  input  wire anpr_pkg::anpr_word_t  MGMT_WDATA,
  output logic [15:0]                MGMT_RDATA,
  output logic                       MGMT_RVALID,
  output logic                       MGMT_HIT,
  // arbitration side, one bit or word per port
  input  wire logic [3:0]            RX_PAGE,
  input  wire logic [63:0]           RX_WORD,
  input  wire logic [3:0]            LP_AN_ABLE,
  input  wire logic [3:0]            TX_BASE,
  input  wire logic [3:0]            BASE_TOGGLE,
  input  wire logic [3:0]            TX_NEXT,
  output logic [63:0]                TX_NP_WORD
);
  anpr_pkg::anpr_word_t rd_word [`ANPR_NPORTS];
  anpr_pkg::anpr_word_t np_word [`ANPR_NPORTS];
  logic [3:0]           hit_mask;

  function automatic logic reg_mapped(input anpr_pkg::anpr_regad_t ad);
    reg_mapped = (ad == `ANPR_OFS_PARTNER) || (ad == `ANPR_OFS_EXPANSION) || (ad == `ANPR_OFS_NEXTPAGE);
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < `ANPR_NPORTS; gi++) begin : g_port
      anpr_port_if pif ();
      logic sel;
      assign sel             = (MGMT_PORT == anpr_pkg::anpr_port_t'(gi));
      assign pif.wr_np       = MGMT_WR && sel && (MGMT_REG == `ANPR_OFS_NEXTPAGE);
      assign pif.rd_exp      = MGMT_RD && sel && (MGMT_REG == `ANPR_OFS_EXPANSION);
      assign pif.wdata       = MGMT_WDATA;
      assign pif.rx_page     = RX_PAGE[gi];
      assign pif.rx_word     = RX_WORD[gi*16 +: 16];
      assign pif.lp_an_able  = LP_AN_ABLE[gi];
      assign pif.tx_base     = TX_BASE[gi];
      assign pif.base_toggle = BASE_TOGGLE[gi];
      assign pif.tx_next     = TX_NEXT[gi];
      assign hit_mask[gi]    = sel;
      anpr_port u_port (
        .clk (CORE_CLK),
        .rst (RST),
        .p   (pif.port)
      );
      always_comb begin
        unique case (MGMT_REG)
          `ANPR_OFS_PARTNER:   rd_word[gi] = pif.partner;
          `ANPR_OFS_EXPANSION: rd_word[gi] = pif.expansion;
          `ANPR_OFS_NEXTPAGE:  rd_word[gi] = pif.nextpage;
          default:             rd_word[gi] = 16'h0000;
        endcase
      end
      assign np_word[gi] = pif.nextpage;
    end
  endgenerate

  // one process owns the whole word so no bit has two drivers
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      TX_NP_WORD <= {`ANPR_NPORTS{`ANPR_NEXTPAGE_RST}};
    end else begin
      for (int i = 0; i < `ANPR_NPORTS; i++) begin
        TX_NP_WORD[i*16 +: 16] <= np_word[i];
      end
    end
  end

  // writes to read-only registers or unmapped addresses are dropped silently
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      MGMT_RDATA  <= 16'h0000;
      MGMT_RVALID <= 1'b0;
      MGMT_HIT    <= 1'b0;
    end else begin
      MGMT_RVALID <= MGMT_RD;
      MGMT_HIT    <= MGMT_RD && reg_mapped(MGMT_REG) && (|hit_mask);
      if (MGMT_RD) begin
        MGMT_RDATA <= rd_word[MGMT_PORT];
      end
    end
  end
endmodule

// ### anpr_bank_monitor.sv
/* checker for the four-port page register bank
   assumes it sees only the anpr_bank ports, bound below */
`timescale 1ns/100ps
module anpr_bank_monitor (
  // watched ports
  input wire logic                  CORE_CLK,
  input wire logic                  RST,
  input wire logic                  MGMT_RD,
  input wire anpr_pkg::anpr_port_t  MGMT_PORT,
  input wire anpr_pkg::anpr_regad_t MGMT_REG,
  input wire logic [15:0]           MGMT_RDATA,
  input wire logic                  MGMT_RVALID,
  input wire logic                  MGMT_HIT,
  input wire logic [3:0]            RX_PAGE,
  input wire logic [3:0]            TX_BASE,
  input wire logic [3:0]            BASE_TOGGLE,
  input wire logic [3:0]            TX_NEXT,
  input wire logic [63:0]           TX_NP_WORD
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  wire rd6 = MGMT_RD && MGMT_REG == 5'h06 && MGMT_PORT == 2'h0;
  wire ev0 = TX_NEXT[0] || TX_BASE[0];
  a_read_answer: assert property (MGMT_RD |=> MGMT_RVALID && MGMT_HIT == ($past(MGMT_REG) inside {[5:7]}))
    else $error("read answer wrong");
  a_exp_fixed: assert property (MGMT_RD && MGMT_REG == 5'h06 |=> MGMT_RDATA[15:4] == 12'h0 && MGMT_RDATA[2])
    else $error("expansion fixed bits wrong");
  a_tx_reset: assert property ($fell(RST) |-> TX_NP_WORD == {4{16'h2001}})
    else $error("next page word not at reset value");
  a_tx_b14: assert property ((TX_NP_WORD & {4{16'h4000}}) == 64'h0)
    else $error("next page bit 14 set");
  a_page_flag: assert property (RX_PAGE[0] ##1 rd6 |=> MGMT_RDATA[1])
    else $error("page flag not set");
  a_flag_clear: assert property (rd6 && !RX_PAGE[0] ##1 !RX_PAGE[0] ##1 rd6 |=> !MGMT_RDATA[1])
    else $error("page flag not cleared by read");
  a_base_toggle: assert property (TX_BASE[0] ##1 !ev0 |=> TX_NP_WORD[11] == !$past(BASE_TOGGLE[0], 2))
    else $error("toggle not loaded from base page");
  a_next_toggle: assert property (TX_NEXT[0] && !$past(ev0) ##1 !ev0 |=> TX_NP_WORD[11] != $past(TX_NP_WORD[11], 2))
    else $error("toggle did not invert");
  c_page_read: cover property (RX_PAGE[0] ##1 rd6);
  c_unmapped: cover property (MGMT_RVALID && !MGMT_HIT);
  c_toggle: cover property (TX_BASE[0] ##[1:20] TX_NEXT[0]);
endmodule

bind anpr_bank anpr_bank_monitor mon_u (.CORE_CLK(CORE_CLK), .RST(RST), .MGMT_RD(MGMT_RD), .MGMT_PORT(MGMT_PORT),
  .MGMT_REG(MGMT_REG), .MGMT_RDATA(MGMT_RDATA), .MGMT_RVALID(MGMT_RVALID), .MGMT_HIT(MGMT_HIT), .RX_PAGE(RX_PAGE),
  .TX_BASE(TX_BASE), .BASE_TOGGLE(BASE_TOGGLE), .TX_NEXT(TX_NEXT), .TX_NP_WORD(TX_NP_WORD));

// ### anpr_partner.sv
/* arbitration-side model: partner pages received and local pages sent
   assumes its tasks are entered just after a rising clock edge */
`timescale 1ns/100ps
module anpr_partner (
  // page events
  input  wire logic  clk,
  output logic [3:0]  rx_page     = 4'h0,
  output logic [63:0] rx_word     = 64'h0,
  output logic [3:0]  lp_an_able  = 4'h0,
  output logic [3:0]  tx_base     = 4'h0,
  output logic [3:0]  base_toggle = 4'h0,
  output logic [3:0]  tx_next     = 4'h0
);
  task send_page(input int p, input logic [15:0] w);
    rx_word[16*p+:16] = w;
    rx_page[p] = 1'b1;
    lp_an_able[p] = 1'b1;
    @(posedge clk);
    #1;
    rx_page[p] = 1'b0;
    // word is not held after the pulse, so a late sample shows garbage
    rx_word[16*p+:16] = ~w;
  endtask
  task send_tx(input int p, input logic base, input logic tg);
    tx_base[p] = base;
    tx_next[p] = !base;
    base_toggle[p] = tg;
    @(posedge clk);
    #1;
    tx_base[p] = 1'b0;
    tx_next[p] = 1'b0;
  endtask
endmodule

// ### anpr_bank_tb_top.sv
/* self-checking bench for the page register bank
   assumes anpr_partner drives the arbitration side */
`timescale 1ns/100ps
module anpr_bank_tb_top;
  logic                  clk   = 1'b0;
  logic                  rst   = 1'b1;
  logic                  mrd   = 1'b0;
  logic                  mwr   = 1'b0;
  anpr_pkg::anpr_port_t  port  = 2'h0;
  anpr_pkg::anpr_regad_t regad = 5'h00;
  anpr_pkg::anpr_word_t  wdata = 16'h0000;
  anpr_pkg::anpr_word_t  rdata;
  logic                  rvalid;
  logic                  hit;
  logic [3:0]            rx_page, lp_an, tx_base, base_tg, tx_next;
  logic [63:0]           rx_word, tx_np;
  logic [15:0]           pa[4]  = '{default: 16'h0};
  logic [15:0]           npw[4] = '{default: 16'h2001};
  logic                  pr[4]  = '{default: 1'b0};
  logic                  npa[4] = '{default: 1'b0};
  logic                  an[4]  = '{default: 1'b0};
  logic                  tg[4]  = '{default: 1'b0};
  int                    mismatches = 0;
  int                    checks_done = 0;
  int                    p;
  logic [15:0]           w;
  initial forever #10 clk = ~clk;
  anpr_bank dut_u (.CORE_CLK(clk), .RST(rst), .MGMT_RD(mrd), .MGMT_WR(mwr), .MGMT_PORT(port), .MGMT_REG(regad),
    .MGMT_WDATA(wdata), .MGMT_RDATA(rdata), .MGMT_RVALID(rvalid), .MGMT_HIT(hit), .RX_PAGE(rx_page),
    .RX_WORD(rx_word), .LP_AN_ABLE(lp_an), .TX_BASE(tx_base), .BASE_TOGGLE(base_tg), .TX_NEXT(tx_next),
    .TX_NP_WORD(tx_np));
  anpr_partner part_u (.clk(clk), .rx_page(rx_page), .rx_word(rx_word), .lp_an_able(lp_an), .tx_base(tx_base),
    .base_toggle(base_tg), .tx_next(tx_next));
  task chk(input string n, input logic [15:0] e, input logic [15:0] s);
    checks_done++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  function logic [15:0] mdl(input int q, input int r);
    case (r)
      5: return pa[q];
      6: return {12'h0, npa[q], 1'b1, pr[q], an[q]};
      7: return npw[q] | {4'h0, tg[q], 11'h0};
      default: return 16'h0;
    endcase
  endfunction
  task read_reg(input int q, input int r);
    port = q[1:0];
    regad = r[4:0];
    mrd = 1'b1;
    @(posedge clk);
    #1;
    mrd = 1'b0;
    chk("read data", mdl(q, r), rdata);
    chk("valid", 16'h0001, {15'h0, rvalid});
    chk("hit", {15'h0, (r >= 5 && r <= 7)}, {15'h0, hit});
    if (r == 6) pr[q] = 1'b0;
    @(posedge clk);
    #1;
  endtask
  task write_reg(input int q, input int r, input logic [15:0] d);
    port = q[1:0];
    regad = r[4:0];
    wdata = d;
    mwr = 1'b1;
    @(posedge clk);
    #1;
    mwr = 1'b0;
    if (r == 7) npw[q] = d & 16'hb7ff;
    @(posedge clk);
    #1;
  endtask
  task chk_tx(input int q);
    @(posedge clk);
    #1;
    chk("tx word", mdl(q, 7), tx_np[16*q+:16]);
  endtask
  task give_verdict;
    $display("mismatches %0d checks %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #20000;
    mismatches++;
    give_verdict;
  end
  initial begin
    void'($urandom(83));
    repeat (5) @(posedge clk);
    #1;
    rst = 1'b0;
    for (int q = 0; q < 4; q++) for (int r = 5; r < 9; r++) read_reg(q, r);
    for (int i = 0; i < 8; i++) begin
      p = i % 4;
      w = 16'($urandom);
      write_reg(p, 5, w);
      write_reg(p, 6, w);
      part_u.send_page(p, w);
      pa[p] = w;
      pr[p] = 1'b1;
      an[p] = 1'b1;
      npa[p] = npa[p] | w[15];
      read_reg(p, 6);
      read_reg(p, 6);
      read_reg(p, 5);
      write_reg(p, 7, ~w);
      chk_tx(p);
      read_reg(p, 7);
      part_u.send_tx(p, 1'b1, w[11]);
      tg[p] = ~w[11];
      npa[p] = 1'b0;
      chk_tx(p);
      part_u.send_tx(p, 1'b0, w[11]);
      tg[p] = ~tg[p];
      chk_tx(p);
      read_reg((p + 1) % 4, 5);
    end
    give_verdict;
  end
endmodule
